//--- rtl/adcct_pkg.sv
// package with timing tables and control layout for the conversion sequencer
package adcct_pkg;
  // control register layout: upper nibble selects timing, bit 3 powers off
  localparam int CTRL_WIDTH     = 8;
  localparam int CTS_POS        = 6;
  localparam int STS_POS        = 4;
  localparam int PWR_OFF_POS    = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int RESULT_WIDTH   = 10;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [9:0] RESULT_MSB   = 10'h200;
  // cycle counter width: largest phase is 1600 half periods = 800 cycles
  localparam int CNT_WIDTH      = 11;
  // phase lengths in half cpu periods, index {cts, sts}
  localparam int SAMPLE_HALF [16] = '{
    120, 140, 200, 400,  120, 140, 200, 400,
    480, 560, 800, 1600, 240, 280, 400, 800};
  localparam int COMPARE_HALF [16] = '{
    240, 280, 280, 280,  240, 280, 280, 280,
    960, 1120, 1120, 1120, 480, 560, 560, 560};
  localparam int EXTRA_HALF [16] = '{
    28, 16, 52, 44,  28, 16, 52, 44,
    100, 52, 196, 164, 52, 28, 100, 52};
  // two half periods make one clock cycle
  localparam int HALF_PER_CYCLE = 2;
  typedef enum logic [1:0] {
    ADCCT_IDLE, ADCCT_SAMPLE, ADCCT_COMPARE, ADCCT_EXTRA} adcct_state_t;
endpackage

//--- rtl/adcct_seq.sv
// conversion phase sequencer of the successive approximation converter
// Operation
// - sample first, then ten comparison steps
// - phase lengths counted from cpu clock
// - upper control nibble selects phase timing
// - durations in half cpu period units
// - conversion select 00 timing table
// - conversion select 11 timing table
// - conversion select 10 timing table
// - total time sums sample, compare, extra
// - unsigned 10-bit code 000 to 3ff
// - power-off bit disables analog circuitry
`timescale 1ns/1ps
module adcct_seq (
  // clock and reset
  input  wire logic       SYS_CLK_IN,
  input  wire logic       RST_IN,
  // control register value and start request
  input  wire logic [7:0] CTRL_IN,
  input  wire logic       START_IN,
  // comparator answer: high when sampled input is at or above the dac level
  input  wire logic       CMP_HIGH_IN,
  // analog front end control
  output logic            SAMPLE_OUT,
  output logic            ANALOG_ON_OUT,
  output logic [9:0]      DAC_CODE_OUT,
  // status and result
  output logic            BUSY_OUT,
  output logic            DONE_OUT,
  output logic [9:0]      RESULT_OUT
);
  // phase state and the down counter of the running phase
  adcct_pkg::adcct_state_t state;
  adcct_pkg::adcct_state_t next_state;
  logic [10:0]             cnt;
  logic [10:0]             next_cnt;

  // successive approximation trial code and the bit under test
  logic [9:0]              trial;
  logic [9:0]              next_trial;
  logic [9:0]              bitsel;
  logic [9:0]              next_bitsel;

  // result register and its completion pulse
  logic [9:0]              result;
  logic [9:0]              next_result;
  logic                    done;
  logic                    next_done;

  // decoded control fields
  logic [1:0]              cts;
  logic [1:0]              sts;
  logic [3:0]              sel;
  logic                    pwr_off;
  logic                    reserved_sel;
  logic                    start_ok;

  // phase lengths in whole clock cycles
  logic [10:0]             samp_len;
  logic [10:0]             comp_len;
  logic [10:0]             extra_len;
  logic [10:0]             step_len;

  // phase progress decodes
  logic                    last_cnt;
  logic                    in_sample;
  logic                    in_compare;
  logic                    in_extra;
  logic                    step_tick;

  // ------------------------------------------------------------------
  // control decode
  // ------------------------------------------------------------------
  assign cts          = CTRL_IN[adcct_pkg::CTS_POS +: 2];
  assign sts          = CTRL_IN[adcct_pkg::STS_POS +: 2];
  assign sel          = {cts, sts};
  assign pwr_off      = CTRL_IN[adcct_pkg::PWR_OFF_POS];

  // reserved select 01 is refused so that no undefined timing runs
  assign reserved_sel = (cts == 2'b01);

  assign start_ok     = START_IN
                        && !pwr_off
                        && !reserved_sel;

  // ------------------------------------------------------------------
  // phase lengths
  // ------------------------------------------------------------------
  // table values are half cpu periods; two of them make one cycle, and
  // every table entry is even, so no rounding is lost here
  always_comb begin
    samp_len  = 11'(adcct_pkg::SAMPLE_HALF[sel]
                    / adcct_pkg::HALF_PER_CYCLE);
    comp_len  = 11'(adcct_pkg::COMPARE_HALF[sel]
                    / adcct_pkg::HALF_PER_CYCLE);
    extra_len = 11'(adcct_pkg::EXTRA_HALF[sel]
                    / adcct_pkg::HALF_PER_CYCLE);
    // comparison phase split evenly over ten steps
    step_len  = 11'(comp_len / 11'd10);
  end

  // ------------------------------------------------------------------
  // phase progress
  // ------------------------------------------------------------------
  assign last_cnt   = (cnt == 11'd0);
  assign in_sample  = (state == adcct_pkg::ADCCT_SAMPLE);
  assign in_compare = (state == adcct_pkg::ADCCT_COMPARE);
  assign in_extra   = (state == adcct_pkg::ADCCT_EXTRA);

  // a bit is decided at the end of each step, the lsb at the phase end;
  // the counter runs down, so step ends fall on multiples of step_len
  assign step_tick  = in_compare
                      && (bitsel != 10'h000)
                      && ((cnt % step_len) == 11'd0);

  // ------------------------------------------------------------------
  // phase state and counter
  // ------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      adcct_pkg::ADCCT_IDLE: begin
        if (start_ok) begin
          next_state = adcct_pkg::ADCCT_SAMPLE;
          next_cnt   = samp_len - 11'd1;
        end
      end
      adcct_pkg::ADCCT_SAMPLE: begin
        if (last_cnt) begin
          next_state = adcct_pkg::ADCCT_COMPARE;
          next_cnt   = comp_len - 11'd1;
        end else begin
          next_cnt = cnt - 11'd1;
        end
      end
      adcct_pkg::ADCCT_COMPARE: begin
        if (last_cnt) begin
          next_state = adcct_pkg::ADCCT_EXTRA;
          next_cnt   = extra_len - 11'd1;
        end else begin
          next_cnt = cnt - 11'd1;
        end
      end
      adcct_pkg::ADCCT_EXTRA: begin
        if (last_cnt) begin
          next_state = adcct_pkg::ADCCT_IDLE;
        end else begin
          next_cnt = cnt - 11'd1;
        end
      end
      default: begin
        next_state = adcct_pkg::ADCCT_IDLE;
        next_cnt   = '0;
      end
    endcase
    // power-off aborts any conversion in progress
    if (pwr_off) begin
      next_state = adcct_pkg::ADCCT_IDLE;
      next_cnt   = '0;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      state <= adcct_pkg::ADCCT_IDLE;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // ------------------------------------------------------------------
  // successive approximation
  // ------------------------------------------------------------------
  // the trial code drives the dac; the comparator answer for the bit
  // under test decides whether it stays, and the next bit is tried
  always_comb begin
    next_trial  = trial;
    next_bitsel = bitsel;
    case (state)
      adcct_pkg::ADCCT_SAMPLE: begin
        if (last_cnt) begin
          next_bitsel = adcct_pkg::RESULT_MSB;
          next_trial  = adcct_pkg::RESULT_MSB;
        end
      end
      adcct_pkg::ADCCT_COMPARE: begin
        if (step_tick) begin
          next_bitsel = bitsel >> 1;
          if (CMP_HIGH_IN) begin
            next_trial = trial | (bitsel >> 1);
          end else begin
            next_trial = (trial & ~bitsel) | (bitsel >> 1);
          end
        end
      end
      default: begin
        next_trial  = trial;
        next_bitsel = bitsel;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      trial  <= adcct_pkg::RESULT_RESET;
      bitsel <= '0;
    end else begin
      trial  <= next_trial;
      bitsel <= next_bitsel;
    end
  end

  // ------------------------------------------------------------------
  // result register
  // ------------------------------------------------------------------
  // the transfer waits for the end of the extra phase; an abort by
  // power-off leaves the previous result in place
  always_comb begin
    next_result = result;
    next_done   = 1'b0;
    if (in_extra && last_cnt && !pwr_off) begin
      next_result = trial;
      next_done   = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      result <= adcct_pkg::RESULT_RESET;
      done   <= 1'b0;
    end else begin
      result <= next_result;
      done   <= next_done;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------

  assign SAMPLE_OUT    = in_sample;
  assign ANALOG_ON_OUT = !pwr_off;
  assign DAC_CODE_OUT  = trial;
  assign BUSY_OUT      = (state != adcct_pkg::ADCCT_IDLE);
  assign DONE_OUT      = done;
  assign RESULT_OUT    = result;
endmodule

//--- sim/adcct_seq_checker.sv
// port assertions for the conversion sequencer
`timescale 1ns/1ps
module adcct_seq_checker (
  input wire logic       SYS_CLK_IN,
  input wire logic       RST_IN,
  input wire logic [7:0] CTRL_IN,
  input wire logic       START_IN,
  input wire logic       SAMPLE_OUT,
  input wire logic       ANALOG_ON_OUT,
  input wire logic       BUSY_OUT,
  input wire logic       DONE_OUT,
  input wire logic [9:0] RESULT_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);
  // fastest setting keeps the exact phase checks within a plain delay
  sequence s_fast; $rose(SAMPLE_OUT) && CTRL_IN[7:4] == 4'h0; endsequence
  property p_on; ANALOG_ON_OUT == !CTRL_IN[3]; endproperty
  a_on: assert property (p_on) else $error("power state wrong");
  property p_go; !BUSY_OUT && START_IN && !CTRL_IN[3] &&
    CTRL_IN[7:6] != 2'h1 |=> SAMPLE_OUT && BUSY_OUT; endproperty
  a_go: assert property (p_go) else $error("start lost");
  property p_smp; SAMPLE_OUT |-> BUSY_OUT; endproperty
  a_smp: assert property (p_smp) else $error("sample while idle");
  property p_rsv; !BUSY_OUT && CTRL_IN[7:6] == 2'h1 |=> !BUSY_OUT; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved ran");
  property p_pulse; DONE_OUT |=> !DONE_OUT; endproperty
  a_pulse: assert property (p_pulse) else $error("done too long");
  property p_hold; !DONE_OUT |-> $stable(RESULT_OUT); endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_slen; s_fast |-> ##59 SAMPLE_OUT ##1 !SAMPLE_OUT; endproperty
  a_slen: assert property (p_slen) else $error("sample length");
  property p_time; s_fast |-> ##194 DONE_OUT; endproperty
  a_time: assert property (p_time) else $error("conversion length");
endmodule
bind adcct_seq adcct_seq_checker u_chk (.SYS_CLK_IN(SYS_CLK_IN),
  .RST_IN(RST_IN), .CTRL_IN(CTRL_IN), .START_IN(START_IN),
  .SAMPLE_OUT(SAMPLE_OUT), .ANALOG_ON_OUT(ANALOG_ON_OUT),
  .BUSY_OUT(BUSY_OUT), .DONE_OUT(DONE_OUT), .RESULT_OUT(RESULT_OUT));

//--- sim/adcct_analog.sv
// ideal analog source and comparator facing the sequencer
`timescale 1ns/1ps
module adcct_analog (
  input  wire logic [9:0] level_in,
  input  wire logic [9:0] dac_in,
  output logic            cmp_high_out
);
  // reference spans full scale, so the ideal code equals the level
  assign cmp_high_out = level_in >= dac_in;
endmodule

//--- sim/test_adc_conversion_timing.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module test_adc_conversion_timing;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] ctrl = 8'h00;
  logic       start = 1'b0;
  logic [9:0] level = 10'h000;
  logic       cmp, smp, on, busy, done;
  logic [9:0] dac, res;
  int         fails = 0;
  int         n_checks = 0;
  always #2.5 clk = ~clk;
  adcct_analog src (.level_in(level), .dac_in(dac), .cmp_high_out(cmp));
  adcct_seq uut (.SYS_CLK_IN(clk), .RST_IN(rst), .CTRL_IN(ctrl),
    .START_IN(start), .CMP_HIGH_IN(cmp), .SAMPLE_OUT(smp),
    .ANALOG_ON_OUT(on), .DAC_CODE_OUT(dac), .BUSY_OUT(busy),
    .DONE_OUT(done), .RESULT_OUT(res));
  task automatic chk(string what, logic [11:0] exp, logic [11:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // starts right after the previous done, so runs are back to back
  task automatic convert(logic [7:0] c, logic [9:0] lv, int halfs);
    int n;
    n = 0;
    ctrl = c;
    level = lv;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    while (done !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000) begin
      fails++;
      close_out();
    end else begin
      chk("cycles", 12'(halfs / 2), 12'(n));
      chk("result", {2'h0, lv}, {2'h0, res});
      chk("dac", {2'h0, lv}, {2'h0, dac});
    end
  endtask
  task automatic t_table;
    convert(8'h00, 10'h3ff, 388);
    convert(8'he0, 10'h155, 1060);
    convert(8'hb0, 10'h000, 2884);
    $display("timing table done");
  endtask
  task automatic t_refuse;
    ctrl = 8'h40;
    start = 1'b1;
    repeat (10) @(negedge clk);
    chk("busy", 12'h0, {11'h0, busy});
    chk("analog", 12'h1, {11'h0, on});
    ctrl = 8'h48;
    start = 1'b1;
    repeat (10) @(negedge clk);
    chk("busy", 12'h0, {11'h0, busy});
    chk("analog", 12'h0, {11'h0, on});
    ctrl = 8'h00;
    @(negedge clk);
    start = 1'b0;
    repeat (20) @(negedge clk);
    ctrl = 8'h08;
    repeat (2) @(negedge clk);
    chk("abort", 12'h0, {11'h0, busy});
    ctrl = 8'h00;
    @(negedge clk);
    chk("analog", 12'h1, {11'h0, on});
    $display("refusals done");
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_table();
    t_refuse();
    close_out();
  end
endmodule
